// *** rtl/intr_mask_pkg.sv ***
// Package with register map, field positions and types for the interrupt enable mask block
package intr_mask_pkg;
   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [11:0] PRIMARY_STATUS_OFFSET = 12'h010;
   localparam logic [11:0] ENABLE_MASK_OFFSET    = 12'h014;
   localparam logic [11:0] EXTENDED_STATUS_OFFSET = 12'h018;
   localparam logic [11:0] ROUTING_CTRL_OFFSET   = 12'h01c;
   localparam logic [11:0] EXT_ENABLE_OFFSET     = 12'h020;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int MASTER_ENABLE_BIT  = 2;
   localparam int EXT_ROUTE_BIT      = 0;
   localparam int PHY_EVENT_BIT      = 3;
   localparam int PHY_REG_DATA_BIT   = 4;
   localparam int BUS_RESET_BIT      = 5;
   localparam int SELF_ID_ERROR_BIT  = 6;
   localparam int TX_READY_BIT       = 7;
   localparam int ASYNC_PKT_RX_BIT   = 8;
   localparam int CMD_RESET_RX_BIT   = 9;
   localparam int ASYNC_CTRL_ACK_BIT = 10;
   localparam int ISO_PKT_RX_BIT     = 11;
   localparam int ASYNC_BULK_ACK_BIT = 12;
   localparam int ISO_TX_STUCK_BIT   = 13;
   localparam int ASYNC_TX_STUCK_BIT = 14;
   localparam int DATA_CRC_ERROR_BIT = 15;
   localparam int BUSY_ACK_SENT_BIT  = 16;
   localparam int HEADER_ERROR_BIT   = 17;
   localparam int TX_TCODE_ERROR_BIT = 18;
   localparam int CYCLE_SECONDS_BIT  = 22;
   localparam int CYCLE_STARTED_BIT  = 23;
   localparam int CYCLE_DONE_BIT     = 24;
   localparam int CYCLE_PENDING_BIT  = 25;
   localparam int CYCLE_LOST_BIT     = 26;
   localparam int CYCLE_ARB_FAIL_BIT = 27;
   localparam int ARB_RESET_GAP_BIT  = 28;
   localparam int SUBACTION_GAP_BIT  = 29;
   localparam int ISO_ARB_FAIL_BIT   = 31;

   // ----------------------------------------
   // Reset values and writable bits
   // ----------------------------------------
   localparam logic [31:0] ENABLE_MASK_RESET    = 32'h0000_0000;
   localparam logic [31:0] ENABLE_MASK_WRITABLE = 32'hbfc7_fffc;
   localparam logic [31:0] EXT_MASK_RESET       = 32'h0000_0000;
   localparam logic [31:0] ROUTING_CTRL_RESET   = 32'h0000_0000;
   localparam logic [31:0] READ_ZERO            = 32'h0000_0000;

   // APB request bundle
   typedef struct packed {
      logic        sel;
      logic        enable;
      logic        write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } apb_req_t;
endpackage

// *** rtl/link_interrupt_enable_mask.sv ***
// Interrupt enable mask register and interrupt terminal routing with an APB slave
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - All enable bits clear to zero on reset.
// - Enable mask sits at offset 014h, gating primary status at 10h.
// - Bit 2 is master enable routing primary status to interrupt output.
// - Primary and extended status can both drive the interrupt output.
// - Bit 3 gates the physical-layer interrupt status.
// - Bit 4 gates the physical-layer register data received status.
// - Bit 5 gates the bus reset status.
// - Bit 6 gates the self-identification error status.
// - Bit 7 gates the transmitter ready status.
// - Bit 8 gates the asynchronous packet received status.
// - Bit 9 gates the command reset received status.
// - Bit 10 gates the asynchronous control FIFO acknowledge status.
// - Bit 11 gates the isochronous packet received status.
// - Bit 12 gates the asynchronous bulk FIFO acknowledge status.
// - Bits 13 and 14 gate isochronous and asynchronous transmit FIFO stuck.
// - Bits 15 to 18 gate CRC, busy ack, header and tcode errors.
// - Bits 22 and 23 gate cycle seconds and cycle started.
// - Bits 24 to 27 gate cycle done, pending, lost, arbitration failed.
// - Bits 28 and 29 gate arbitration reset gap and subaction gap.
// - Bit 31 gates isochronous arbitration failed status.
// - Each enable bit shares its position with its status bit.
module link_interrupt_enable_mask (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [11:0]                paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic                       soft_reset,
   input  wire logic [31:0]                primary_interrupt_status,
   input  wire logic [31:0]                extended_interrupt_status,
   output logic                            interrupt_out
);
   import intr_mask_pkg::*;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   intr_mask_pkg::apb_req_t req;
   logic        wr_access;
   logic        rd_access;
   logic        hit_mask;
   logic        hit_ext;
   logic        hit_route;
   logic        hit_primary;
   logic        hit_extstat;
   logic        hit_any;
   logic [31:0] nxt_prdata;

   logic [31:0] interrupt_enable_mask_ff;
   logic [31:0] ext_enable_mask_ff;
   logic [31:0] routing_ctrl_ff;
   logic [31:0] prdata_ff;
   logic        pslverr_ff;
   logic        interrupt_ff;
   logic        master_interrupt_enable;
   logic        ext_route_enable;
   logic [31:0] primary_qualified;
   logic [31:0] ext_qualified;
   logic        nxt_interrupt;
   logic        primary_path;
   logic        ext_path;

   // ----------------------------------------
   // Named enable fields of the mask
   // ----------------------------------------
   logic        phy_event_enable;
   logic        phy_register_data_enable;
   logic        bus_reset_event_enable;
   logic        self_identification_error_enable;
   logic        transmitter_ready_enable;
   logic        async_packet_received_enable;
   logic        command_reset_received_enable;
   logic        async_control_ack_enable;
   logic        iso_packet_received_enable;
   logic        async_bulk_ack_enable;
   logic        iso_tx_fifo_stuck_enable;
   logic        async_tx_fifo_stuck_enable;
   logic        data_crc_error_enable;
   logic        busy_ack_sent_enable;
   logic        header_error_enable;
   logic        tx_transaction_code_error_enable;
   logic        cycle_seconds_enable;
   logic        cycle_started_enable;
   logic        cycle_done_enable;
   logic        cycle_pending_enable;
   logic        cycle_lost_enable;
   logic        cycle_arbitration_fail_enable;
   logic        arbitration_reset_gap_enable;
   logic        subaction_gap_enable;
   logic        iso_arbitration_fail_enable;
   logic [31:0] enable_fields;

   // Grouped causes of the primary status
   logic        self_cause;
   logic        phy_cause;
   logic        host_cause;
   logic        stuck_cause;
   logic        error_cause;
   logic        cycle_cause;
   logic        gap_cause;
   logic        iso_cause;
   logic        primary_any;

   // Bundle the request
   assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

   // Write strobe in the access phase, read strobe in the setup phase; zero-wait slave
   assign wr_access = req.sel && req.enable && req.write;
   assign rd_access = req.sel && !req.enable && !req.write;
   assign pready    = 1'b1;
   assign pslverr   = pslverr_ff;
   assign prdata    = prdata_ff;

   // Address decode
   assign hit_mask    = (req.addr == ENABLE_MASK_OFFSET);
   assign hit_primary = (req.addr == PRIMARY_STATUS_OFFSET);
   assign hit_extstat = (req.addr == EXTENDED_STATUS_OFFSET);
   assign hit_route   = (req.addr == ROUTING_CTRL_OFFSET);
   assign hit_ext     = (req.addr == EXT_ENABLE_OFFSET);
   assign hit_any     = hit_mask | hit_primary | hit_extstat | hit_route | hit_ext;

   // ----------------------------------------
   // Enable mask register
   // ----------------------------------------
   // Writable enables only; reserved positions held at zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_enable_mask_ff <= ENABLE_MASK_RESET;
      end else if (soft_reset) begin
         interrupt_enable_mask_ff <= ENABLE_MASK_RESET;
      end else if (wr_access && hit_mask) begin
         interrupt_enable_mask_ff <= req.wdata & ENABLE_MASK_WRITABLE;
      end
   end

   // Extended status enables, all bits writable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_enable_mask_ff <= EXT_MASK_RESET;
      end else if (soft_reset) begin
         ext_enable_mask_ff <= EXT_MASK_RESET;
      end else if (wr_access && hit_ext) begin
         ext_enable_mask_ff <= req.wdata;
      end
   end

   // Routing control, only the extended route bit is kept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         routing_ctrl_ff <= ROUTING_CTRL_RESET;
      end else if (soft_reset) begin
         routing_ctrl_ff <= ROUTING_CTRL_RESET;
      end else if (wr_access && hit_route) begin
         routing_ctrl_ff <= {31'h0000_0000, req.wdata[EXT_ROUTE_BIT]};
      end
   end

   // ----------------------------------------
   // Read data and error response
   // ----------------------------------------
   // Read mux for setup phase, registered into the access phase
   always_comb begin
      nxt_prdata = READ_ZERO;
      if (hit_mask) begin
         nxt_prdata = interrupt_enable_mask_ff;
      end else if (hit_primary) begin
         nxt_prdata = primary_interrupt_status;
      end else if (hit_extstat) begin
         nxt_prdata = extended_interrupt_status;
      end else if (hit_route) begin
         nxt_prdata = routing_ctrl_ff;
      end else if (hit_ext) begin
         nxt_prdata = ext_enable_mask_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= READ_ZERO;
      end else if (rd_access) begin
         prdata_ff <= nxt_prdata;
      end
   end

   // Unmapped addresses answer with slave error in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_ff <= 1'b0;
      end else if (req.sel && !req.enable) begin
         pslverr_ff <= !hit_any;
      end else if (!req.sel) begin
         pslverr_ff <= 1'b0;
      end
   end

   // ----------------------------------------
   // Interrupt combining
   // ----------------------------------------
   assign master_interrupt_enable = interrupt_enable_mask_ff[MASTER_ENABLE_BIT];
   assign ext_route_enable        = routing_ctrl_ff[EXT_ROUTE_BIT];

   // Status inputs are latched levels held outside this block.
   // The terminal is a level: it stays high while any enabled
   // cause stays set, and drops one cycle after the cause or
   // its enable goes away. Clearing a status is the job of the
   // status owner; nothing here remembers a past event.
   // Reserved mask bits never reach the gating below.

   // Field views of the enable mask
   // Physical layer and self-identification events
   assign phy_event_enable                 = interrupt_enable_mask_ff[PHY_EVENT_BIT];
   assign phy_register_data_enable         = interrupt_enable_mask_ff[PHY_REG_DATA_BIT];
   assign bus_reset_event_enable           = interrupt_enable_mask_ff[BUS_RESET_BIT];
   assign self_identification_error_enable = interrupt_enable_mask_ff[SELF_ID_ERROR_BIT];

   // Transmit, receive and acknowledge events
   assign transmitter_ready_enable         = interrupt_enable_mask_ff[TX_READY_BIT];
   assign async_packet_received_enable     = interrupt_enable_mask_ff[ASYNC_PKT_RX_BIT];
   assign command_reset_received_enable    = interrupt_enable_mask_ff[CMD_RESET_RX_BIT];
   assign async_control_ack_enable         = interrupt_enable_mask_ff[ASYNC_CTRL_ACK_BIT];
   assign iso_packet_received_enable       = interrupt_enable_mask_ff[ISO_PKT_RX_BIT];
   assign async_bulk_ack_enable            = interrupt_enable_mask_ff[ASYNC_BULK_ACK_BIT];

   // Transmit FIFO stuck
   assign iso_tx_fifo_stuck_enable         = interrupt_enable_mask_ff[ISO_TX_STUCK_BIT];
   assign async_tx_fifo_stuck_enable       = interrupt_enable_mask_ff[ASYNC_TX_STUCK_BIT];

   // Error events
   assign data_crc_error_enable            = interrupt_enable_mask_ff[DATA_CRC_ERROR_BIT];
   assign busy_ack_sent_enable             = interrupt_enable_mask_ff[BUSY_ACK_SENT_BIT];
   assign header_error_enable              = interrupt_enable_mask_ff[HEADER_ERROR_BIT];
   assign tx_transaction_code_error_enable = interrupt_enable_mask_ff[TX_TCODE_ERROR_BIT];

   // Cycle events
   assign cycle_seconds_enable             = interrupt_enable_mask_ff[CYCLE_SECONDS_BIT];
   assign cycle_started_enable             = interrupt_enable_mask_ff[CYCLE_STARTED_BIT];
   assign cycle_done_enable                = interrupt_enable_mask_ff[CYCLE_DONE_BIT];
   assign cycle_pending_enable             = interrupt_enable_mask_ff[CYCLE_PENDING_BIT];
   assign cycle_lost_enable                = interrupt_enable_mask_ff[CYCLE_LOST_BIT];
   assign cycle_arbitration_fail_enable    = interrupt_enable_mask_ff[CYCLE_ARB_FAIL_BIT];

   // Bus gaps
   assign arbitration_reset_gap_enable     = interrupt_enable_mask_ff[ARB_RESET_GAP_BIT];
   assign subaction_gap_enable             = interrupt_enable_mask_ff[SUBACTION_GAP_BIT];

   // Isochronous arbitration
   assign iso_arbitration_fail_enable      = interrupt_enable_mask_ff[ISO_ARB_FAIL_BIT];

   // Enable vector rebuilt by position; reserved places stay zero
   always_comb begin
      enable_fields = '0;
      enable_fields[MASTER_ENABLE_BIT] = master_interrupt_enable;

      // Physical layer and self-identification events
      enable_fields[PHY_EVENT_BIT]      = phy_event_enable;
      enable_fields[PHY_REG_DATA_BIT]   = phy_register_data_enable;
      enable_fields[BUS_RESET_BIT]      = bus_reset_event_enable;
      enable_fields[SELF_ID_ERROR_BIT]  = self_identification_error_enable;

      // Transmit, receive and acknowledge events
      enable_fields[TX_READY_BIT]       = transmitter_ready_enable;
      enable_fields[ASYNC_PKT_RX_BIT]   = async_packet_received_enable;
      enable_fields[CMD_RESET_RX_BIT]   = command_reset_received_enable;
      enable_fields[ASYNC_CTRL_ACK_BIT] = async_control_ack_enable;
      enable_fields[ISO_PKT_RX_BIT]     = iso_packet_received_enable;
      enable_fields[ASYNC_BULK_ACK_BIT] = async_bulk_ack_enable;

      // Transmit FIFO stuck
      enable_fields[ISO_TX_STUCK_BIT]   = iso_tx_fifo_stuck_enable;
      enable_fields[ASYNC_TX_STUCK_BIT] = async_tx_fifo_stuck_enable;

      // Error events
      enable_fields[DATA_CRC_ERROR_BIT] = data_crc_error_enable;
      enable_fields[BUSY_ACK_SENT_BIT]  = busy_ack_sent_enable;
      enable_fields[HEADER_ERROR_BIT]   = header_error_enable;
      enable_fields[TX_TCODE_ERROR_BIT] = tx_transaction_code_error_enable;

      // Cycle events
      enable_fields[CYCLE_SECONDS_BIT]  = cycle_seconds_enable;
      enable_fields[CYCLE_STARTED_BIT]  = cycle_started_enable;
      enable_fields[CYCLE_DONE_BIT]     = cycle_done_enable;
      enable_fields[CYCLE_PENDING_BIT]  = cycle_pending_enable;
      enable_fields[CYCLE_LOST_BIT]     = cycle_lost_enable;
      enable_fields[CYCLE_ARB_FAIL_BIT] = cycle_arbitration_fail_enable;

      // Bus gaps and isochronous arbitration
      enable_fields[ARB_RESET_GAP_BIT]  = arbitration_reset_gap_enable;
      enable_fields[SUBACTION_GAP_BIT]  = subaction_gap_enable;
      enable_fields[ISO_ARB_FAIL_BIT]   = iso_arbitration_fail_enable;
   end

   // Bitwise gating, enable and status share positions
   assign primary_qualified = primary_interrupt_status & enable_fields;

   // Extended path gated bit by bit
   for (genvar b = 0; b < 32; b++) begin : g_ext_gate
      assign ext_qualified[b] = extended_interrupt_status[b] & ext_enable_mask_ff[b];
   end

   // Causes grouped by kind of event
   assign self_cause  = primary_qualified[MASTER_ENABLE_BIT];
   assign phy_cause   = |primary_qualified[SELF_ID_ERROR_BIT:PHY_EVENT_BIT];
   assign host_cause  = |primary_qualified[ASYNC_BULK_ACK_BIT:TX_READY_BIT];
   assign stuck_cause = |primary_qualified[ASYNC_TX_STUCK_BIT:ISO_TX_STUCK_BIT];
   assign error_cause = |primary_qualified[TX_TCODE_ERROR_BIT:DATA_CRC_ERROR_BIT];
   assign cycle_cause = |primary_qualified[CYCLE_ARB_FAIL_BIT:CYCLE_SECONDS_BIT];
   assign gap_cause   = |primary_qualified[SUBACTION_GAP_BIT:ARB_RESET_GAP_BIT];
   assign iso_cause   = primary_qualified[ISO_ARB_FAIL_BIT];
   assign primary_any = self_cause | phy_cause | host_cause | stuck_cause
                      | error_cause | cycle_cause | gap_cause | iso_cause;

   // Primary only through master enable; extended shares the terminal
   assign primary_path  = master_interrupt_enable && primary_any;
   assign ext_path      = ext_route_enable && (|ext_qualified);
   assign nxt_interrupt = primary_path || ext_path;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_ff <= 1'b0;
      end else begin
         interrupt_ff <= nxt_interrupt;
      end
   end

   assign interrupt_out = interrupt_ff;

endmodule

`default_nettype wire

// *** dv/link_interrupt_enable_mask_asserts.sv ***
// Checker of register access and interrupt gating
`timescale 1ns/1ps
`default_nettype none
module link_interrupt_enable_mask_asserts import intr_mask_pkg::*; (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        soft_reset,
   input wire logic [31:0] primary_interrupt_status,
   input wire logic [31:0] extended_interrupt_status,
   input wire logic        interrupt_out
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [31:0] m_ff;
   logic [31:0] x_ff;
   logic        r_ff;
   // Qualified causes and access decode
   wire logic q = m_ff[MASTER_ENABLE_BIT] & |(primary_interrupt_status & m_ff & ENABLE_MASK_WRITABLE);
   wire logic e = r_ff & |(extended_interrupt_status & x_ff);
   wire logic c = q | e;
   wire logic acc = psel & penable;
   wire logic wr = acc & pwrite;
   wire logic rd = acc & ~pwrite;
   wire logic ok = paddr inside {PRIMARY_STATUS_OFFSET, ENABLE_MASK_OFFSET, EXTENDED_STATUS_OFFSET,
                                 ROUTING_CTRL_OFFSET, EXT_ENABLE_OFFSET};
   // Shadow of the enable mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m_ff <= ENABLE_MASK_RESET;
      end else if (soft_reset) begin
         m_ff <= ENABLE_MASK_RESET;
      end else if (wr && paddr == ENABLE_MASK_OFFSET) begin
         m_ff <= pwdata & ENABLE_MASK_WRITABLE;
      end
   end
   // Shadow of the extended enables and the route bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         x_ff <= EXT_MASK_RESET;
         r_ff <= 1'b0;
      end else if (soft_reset) begin
         x_ff <= EXT_MASK_RESET;
         r_ff <= 1'b0;
      end else begin
         if (wr && paddr == EXT_ENABLE_OFFSET) begin
            x_ff <= pwdata;
         end
         if (wr && paddr == ROUTING_CTRL_OFFSET) begin
            r_ff <= pwdata[EXT_ROUTE_BIT];
         end
      end
   end
   a_gated_fire: assert property ($past(c) |-> interrupt_out) else $error("irq missing");
   a_no_cause: assert property (!$past(c) |-> !interrupt_out) else $error("spurious irq");
   a_mask_read: assert property (
      rd && paddr == ENABLE_MASK_OFFSET |-> prdata == $past(m_ff)) else $error("mask rd");
   a_status_view: assert property (
      rd && paddr == PRIMARY_STATUS_OFFSET |-> prdata == $past(primary_interrupt_status)) else $error("status rd");
   a_bad_addr: assert property (
      acc && !ok |-> pslverr && (pwrite || prdata == READ_ZERO)) else $error("bad addr");
   a_good_addr: assert property (acc && ok |-> !pslverr) else $error("false error");
   a_soft_clear: assert property (soft_reset |-> ##2 !interrupt_out) else $error("soft reset irq");
   a_reset_zero: assert property ($rose(presetn) |-> !interrupt_out && !pslverr) else $error("reset value");
endmodule
bind link_interrupt_enable_mask link_interrupt_enable_mask_asserts i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pslverr, .soft_reset, .primary_interrupt_status, .extended_interrupt_status, .interrupt_out);
`default_nettype wire

// *** dv/host_irq_model.sv ***
// Host side model that counts interrupt requests
`timescale 1ns/1ps
`default_nettype none
module host_irq_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        interrupt_out,
   output logic      [15:0] irq_count_ff
);
   // Count each new request on the terminal
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) irq_count_ff <= 16'h0000;
      else if ($rose(interrupt_out)) irq_count_ff <= irq_count_ff + 16'h0001;
endmodule
`default_nettype wire

// *** dv/tb_link_interrupt_enable_mask.sv ***
// Self-checking bench for the interrupt enable mask block
`timescale 1ns/1ps
`default_nettype none
module tb_link_interrupt_enable_mask;
   import intr_mask_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, soft_reset, pready, pslverr, interrupt_out, look;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, st, ext, m;
   logic [33:0] e, exq[$];
   // One rise per writable enable in the sweep, one for the routed extended path
   localparam logic [15:0] IRQ_RISES = 16'h001b;
   logic [15:0] irqs;
   int          fails, samples_checked, cyc;
   link_interrupt_enable_mask i_link_interrupt_enable_mask (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .soft_reset, .primary_interrupt_status(st),
      .extended_interrupt_status(ext), .interrupt_out);
   host_irq_model i_host_irq_model (.pclk, .presetn, .interrupt_out, .irq_count_ff(irqs));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic summarize();
      $display("checked %0d failed %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // One APB transfer; a read notes its expected data
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x);
      logic bad;
      bad = !(a inside {PRIMARY_STATUS_OFFSET, ENABLE_MASK_OFFSET, EXTENDED_STATUS_OFFSET,
                        ROUTING_CTRL_OFFSET, EXT_ENABLE_OFFSET});
      @(posedge pclk);
      if (!w) exq.push_back({1'b0, bad, x});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Note the expected interrupt level two edges on
   task automatic chk_irq(input logic v);
      @(posedge pclk);
      exq.push_back({1'b1, 1'b0, 31'h0000_0000, v});
      look <= 1'b1;
      @(posedge pclk);
      look <= 1'b0;
   endtask
   // Watcher and timeout
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         summarize();
      end
      if (look || (psel && penable && pready && !pwrite)) begin
         e = exq.pop_front();
         samples_checked++;
         if ((e[33] ? {1'b0, 31'h0000_0000, interrupt_out} : {pslverr, prdata}) !== e[32:0]) begin
            fails++;
            $display("Error %0t: irq %b err %b data %h want %h", $time, interrupt_out, pslverr, prdata, e[32:0]);
         end
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, soft_reset, look, paddr, pwdata, st, ext} = '0;
      void'($urandom(32'h972c));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ENABLE_MASK_OFFSET, 32'h0000_0000, ENABLE_MASK_RESET);
      apb(1'b0, 12'h040, 32'h0000_0000, READ_ZERO);
      apb(1'b1, ENABLE_MASK_OFFSET, 32'hffff_ffff, 32'h0000_0000);
      apb(1'b0, ENABLE_MASK_OFFSET, 32'h0000_0000, ENABLE_MASK_WRITABLE);
      // Each status bit with its enable set, then cleared
      for (int i = 0; i < 32; i++) begin
         st <= 32'h0000_0001 << i;
         m = $urandom | 32'h0000_0004 | (32'h0000_0001 << i);
         apb(1'b1, ENABLE_MASK_OFFSET, m, 32'h0000_0000);
         chk_irq(ENABLE_MASK_WRITABLE[i]);
         m = ($urandom | 32'h0000_0004) & ~(32'h0000_0001 << i);
         apb(1'b1, ENABLE_MASK_OFFSET, m, 32'h0000_0000);
         chk_irq(1'b0);
      end
      // Master off before all status bits rise, so no stray request
      apb(1'b1, ENABLE_MASK_OFFSET, 32'hffff_fffb, 32'h0000_0000);
      st <= 32'hffff_ffff;
      ext <= 32'h0000_0001;
      apb(1'b1, EXT_ENABLE_OFFSET, 32'h0000_0001, 32'h0000_0000);
      chk_irq(1'b0);
      apb(1'b1, ROUTING_CTRL_OFFSET, 32'h0000_0001, 32'h0000_0000);
      chk_irq(1'b1);
      apb(1'b1, PRIMARY_STATUS_OFFSET, 32'h0000_0000, 32'h0000_0000);
      apb(1'b0, PRIMARY_STATUS_OFFSET, 32'h0000_0000, 32'hffff_ffff);
      soft_reset <= 1'b1;
      @(posedge pclk);
      soft_reset <= 1'b0;
      chk_irq(1'b0);
      apb(1'b0, ENABLE_MASK_OFFSET, 32'h0000_0000, ENABLE_MASK_RESET);
      samples_checked++;
      if (irqs !== IRQ_RISES) begin
         fails++;
         $display("Error %0t: %0d interrupt requests, want %0d", $time, irqs, IRQ_RISES);
      end
      summarize();
   end
endmodule
`default_nettype wire
